// file: verilog/bus_master_lane_steering.sv
// Bus-master data path: byte-lane steering, cycle sizing, burst FIFO and status
`timescale 1ns/10ps
`default_nettype none
module bus_master_lane_steering
	import lane_steering_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// Register slave bus
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Memory bus arbitration
	input wire logic mem_grant_in,
	output logic mem_req_out,
	output logic mem_req_oe_out,
	output logic grant_chain_out,
	// Memory bus cycle
	input wire logic mem_ready_in,
	input wire logic [31:0] mem_data_in,
	output logic mem_cycle_out,
	output logic mem_write_out,
	output logic mem_fetch_out,
	output logic mem_burst_last_out,
	output logic [31:0] mem_addr_out,
	output logic [31:0] mem_data_out,
	output logic mem_data_oe_out,
	output logic [3:0] mem_parity_out,
	output logic [3:0] byte_enable_n_out,
	output logic upper_byte_enable_n_out,
	output logic address_bit_zero_out,
	// Instruction fetch
	input wire logic fetch_req_in,
	input wire logic [31:0] fetch_addr_in,
	output logic instr_valid_out,
	output logic [63:0] instr_word_out,
	output logic move_done_out,
	// SCSI-side byte streams
	input wire logic [7:0] scsi_wr_byte_in,
	input wire logic scsi_wr_valid_in,
	output logic scsi_wr_ready_out,
	output logic [7:0] scsi_rd_byte_out,
	output logic scsi_rd_valid_out,
	input wire logic scsi_rd_ready_in,
	// SCSI core latch state
	input wire logic scsi_out_latch_full_in,
	input wire logic scsi_out_holding_full_in,
	input wire logic scsi_in_latch_full_in,
	input wire logic [3:0] scsi_fifo_count_in
);
	localparam int AW = $clog2(FIFO_DEPTH);

	// Bursts of eight longwords must fit, and pointers wrap by power of two
	if (FIFO_DEPTH < 32 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_check
		$error("FIFO_DEPTH must be a power of two of at least 32");
	end

	// State
	eng_state_t state_reg;
	logic [7:0] dma_mode_reg;
	logic [7:0] dma_control_reg;
	logic [31:0] next_address_reg;
	logic [23:0] byte_count_reg;
	logic [31:0] fetch_addr_reg;
	logic [3:0] fetch_left_reg;
	logic [63:0] instr_buf_reg;
	logic fetching_reg;
	logic fetch_pend_reg;
	logic move_active_reg;
	logic [3:0] beats_reg;
	logic [7:0] fifo_mem [0:FIFO_DEPTH-1];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] fifo_count_reg;
	logic [AW:0] fifo_count_next;

	// Mode decode
	wire fixed_address_mode = dma_mode_reg[MODE_FIXED_ADDR_BIT];
	wire to_memory = dma_mode_reg[MODE_TO_MEMORY_BIT];
	wire wired_or = dma_mode_reg[MODE_WIRED_OR_BIT];
	wire legacy_word_mode = dma_mode_reg[MODE_LEGACY_BIT];
	wire narrow_bus_select = dma_mode_reg[MODE_NARROW_BIT];
	wire [1:0] burst_code = dma_mode_reg[MODE_BURST_LSB +: 2];
	wire data_width16 = legacy_word_mode | narrow_bus_select;
	wire width16 = fetching_reg ? dma_control_reg[CTRL_SCRIPT16_BIT] : data_width16;

	// Current cycle source: fetch pointer or next address
	wire [31:0] cur_addr = fetching_reg ? fetch_addr_reg : next_address_reg;
	wire [23:0] cur_cnt = fetching_reg ? {20'h00000, fetch_left_reg} : byte_count_reg;

	// Cycle size: bytes left to the bus-width boundary, capped by the count
	wire [2:0] room = width16 ? (3'h2 - {2'h0, cur_addr[0]})
		: (3'h4 - {1'h0, cur_addr[1:0]});
	wire [2:0] beat_n = (cur_cnt < {21'h000000, room}) ? cur_cnt[2:0] : room;
	wire [23:0] cnt_after = cur_cnt - {21'h000000, beat_n};

	// Per-byte offsets, bus lanes and taps
	logic [1:0] beat_off [0:3];
	logic [1:0] bus_lane [0:3];
	logic [3:0] byte_on;
	logic [7:0] rx_byte [0:3];
	logic [7:0] fifo_tap [0:3];
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign beat_off[g] = cur_addr[1:0] + 2'(g);
		// Even bytes ride the low lane, odd bytes the high lane on 16-bit
		assign bus_lane[g] = width16 ? {1'b0, beat_off[g][0]} : beat_off[g];
		assign byte_on[g] = 3'(g) < beat_n;
		assign rx_byte[g] = mem_data_in[{bus_lane[g], 3'h0} +: 8];
		assign fifo_tap[g] = fifo_mem[rd_ptr_reg + AW'(g)];
	end

	// Lane usage and write data steering
	logic [3:0] lane_used;
	logic [31:0] wdata;
	always_comb begin
		lane_used = 4'h0;
		wdata = 32'h00000000;
		for (int j = 0; j < 4; j++) begin
			if (byte_on[j]) begin
				lane_used[beat_off[j]] = 1'b1;
				wdata[{bus_lane[j], 3'h0} +: 8] = fifo_tap[j];
			end
		end
	end

	// Per-lane odd parity on outgoing data
	logic [3:0] wpar;
	for (genvar p = 0; p < 4; p++) begin : g_par
		assign wpar[p] = ~^wdata[8*p +: 8];
	end

	// Legacy signalling: upper enable marks an odd byte, A0 marks an odd start
	wire bhe_n = ~(lane_used[1] | lane_used[3]);
	wire [3:0] be_n = legacy_word_mode ? 4'hF : ~lane_used;
	wire [31:0] bus_addr = legacy_word_mode ? cur_addr : {cur_addr[31:2], 2'h0};

	// Instruction assembly from the fetched lanes
	wire [2:0] fetch_idx = 3'(FETCH_BYTES - fetch_left_reg);
	logic [63:0] instr_merge;
	always_comb begin
		instr_merge = instr_buf_reg;
		for (int j = 0; j < 4; j++) begin
			if (byte_on[j]) begin
				instr_merge[{3'(fetch_idx + 3'(j)), 3'h0} +: 8] = rx_byte[j];
			end
		end
	end

	// Burst sizing: two, four or eight words of the data width
	wire [3:0] burst_words = (burst_code == BURST_MAX_CODE) ? BURST_MAX_WORDS
		: (BURST_MIN_WORDS << burst_code);
	wire [5:0] burst_bytes = data_width16 ? {1'b0, burst_words, 1'b0} : {burst_words, 2'h0};
	wire [23:0] want = (byte_count_reg < {18'h00000, burst_bytes}) ? byte_count_reg
		: {18'h00000, burst_bytes};
	wire [AW:0] fifo_free = (AW+1)'(FIFO_DEPTH) - fifo_count_reg;
	wire [AW:0] avail = to_memory ? fifo_count_reg : fifo_free;
	wire [23:0] avail_after = 24'(avail) - {21'h000000, beat_n};
	wire [23:0] need_next = (cnt_after < 24'h000004) ? cnt_after : 24'h000004;

	// Engine conditions
	wire move_ready = move_active_reg && (byte_count_reg != 24'h000000)
		&& (24'(avail) >= want);
	wire beat_done = (state_reg == ST_BEAT) && mem_ready_in;
	wire last_byte_beat = cnt_after == 24'h000000;
	wire burst_more = ({1'b0, beats_reg} + 5'h01 < {1'b0, burst_words}) && (avail_after >= need_next);
	wire fetch_accept = (state_reg == ST_IDLE) && fetch_pend_reg;
	wire want_bus = (state_reg != ST_IDLE) || fetch_pend_reg || move_ready;

	// FIFO traffic: SCSI side moves one byte, engine up to four
	wire scsi_push = to_memory && scsi_wr_valid_in && scsi_wr_ready_out;
	wire scsi_pop = !to_memory && scsi_rd_valid_out && scsi_rd_ready_in;
	wire eng_move = beat_done && !fetching_reg;
	wire [2:0] push_n = to_memory ? {2'h0, scsi_push} : (eng_move ? beat_n : 3'h0);
	wire [2:0] pop_n = to_memory ? (eng_move ? beat_n : 3'h0) : {2'h0, scsi_pop};
	wire [AW:0] count_after_pop = fifo_count_reg - (AW+1)'(pop_n);
	wire [AW-1:0] rd_ptr_next = rd_ptr_reg + AW'(pop_n);
	assign fifo_count_next = count_after_pop + (AW+1)'(push_n);

	// Slave bus decode
	wire avs_req = avs_read_in | avs_write_in;
	wire avs_wr_take = avs_write_in && !avs_waitrequest_out;
	wire sel_mode = avs_address_in == OFS_DMA_MODE;
	wire sel_ctrl = avs_address_in == OFS_DMA_CONTROL;
	wire sel_addr = avs_address_in == OFS_NEXT_ADDRESS;
	wire sel_cnt = avs_address_in == OFS_BYTE_COUNT;
	wire [7:0] status_one = {scsi_in_latch_full_in, scsi_out_holding_full_in,
		scsi_out_latch_full_in, 5'h00};
	wire [7:0] status_two = {scsi_fifo_count_in, 4'h0};
	wire [7:0] dma_fifo_reg = {move_active_reg | fetching_reg, 7'(fifo_count_reg)};
	wire sw_start = avs_wr_take && sel_ctrl && avs_byteenable_in[0]
		&& avs_writedata_in[CTRL_START_BIT];

	// Read data selection; unmapped offsets read zero
	logic [31:0] rd_mux;
	assign rd_mux = sel_mode ? {24'h000000, dma_mode_reg}
		: sel_ctrl ? {24'h000000, dma_control_reg}
		: sel_addr ? next_address_reg
		: sel_cnt ? {8'h00, byte_count_reg}
		: (avs_address_in == OFS_SCSI_STATUS_ONE) ? {24'h000000, status_one}
		: (avs_address_in == OFS_SCSI_STATUS_TWO) ? {24'h000000, status_two}
		: (avs_address_in == OFS_DMA_FIFO) ? {24'h000000, dma_fifo_reg}
		: (avs_address_in == OFS_INSTR_LOW) ? instr_buf_reg[31:0]
		: (avs_address_in == OFS_INSTR_HIGH) ? instr_buf_reg[63:32]
		: 32'h00000000;

	// Byte-lane merge for register writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
			input logic [31:0] new_val, input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				res[8*k +: 8] = new_val[8*k +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	wire [31:0] addr_wr = lane_merge(next_address_reg, avs_writedata_in, avs_byteenable_in);
	wire [31:0] cnt_wr = lane_merge({8'h00, byte_count_reg}, avs_writedata_in, avs_byteenable_in);

	// Slave handshake: one wait cycle, then answer with registered data
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h00000000;
		end else begin
			avs_waitrequest_out <= !(avs_req && avs_waitrequest_out);
			if (avs_read_in && avs_waitrequest_out) begin
				avs_readdata_out <= rd_mux;
			end
		end
	end

	// Mode and control registers; start bit is a self-clearing strobe
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			dma_mode_reg <= DMA_MODE_RST;
			dma_control_reg <= DMA_CONTROL_RST;
		end else if (avs_wr_take && avs_byteenable_in[0]) begin
			if (sel_mode) begin
				dma_mode_reg <= avs_writedata_in[7:0];
			end
			if (sel_ctrl) begin
				dma_control_reg <= {avs_writedata_in[7:2], 1'b0, avs_writedata_in[0]};
			end
		end
	end

	// Engine sequencing
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state_reg <= ST_IDLE;
			fetching_reg <= 1'b0;
			beats_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					beats_reg <= 4'h0;
					if (fetch_pend_reg) begin
						fetching_reg <= 1'b1;
						state_reg <= ST_ARB;
					end else if (move_ready) begin
						state_reg <= ST_ARB;
					end
				end
				ST_ARB: begin
					if (mem_grant_in) begin
						state_reg <= ST_SET;
					end
				end
				ST_SET: begin
					state_reg <= ST_BEAT;
				end
				ST_BEAT: begin
					if (mem_ready_in) begin
						beats_reg <= beats_reg + 4'h1;
						if (last_byte_beat) begin
							fetching_reg <= 1'b0;
							state_reg <= ST_IDLE;
						end else if (fetching_reg || burst_more) begin
							state_reg <= ST_SET;
						end else begin
							// Release the bus; the next burst rearbitrates
							state_reg <= ST_IDLE;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Fetch request capture; a new strobe wins over the clear on acceptance
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			fetch_pend_reg <= 1'b0;
		end else begin
			fetch_pend_reg <= fetch_req_in | (fetch_pend_reg & !fetch_accept);
		end
	end

	// Fetch pointer and instruction buffer
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			fetch_addr_reg <= 32'h00000000;
			fetch_left_reg <= 4'h0;
			instr_buf_reg <= 64'h0000000000000000;
		end else if (fetch_accept) begin
			fetch_addr_reg <= fetch_addr_in;
			fetch_left_reg <= FETCH_BYTES;
		end else if (beat_done && fetching_reg) begin
			fetch_addr_reg <= fetch_addr_reg + {29'h00000000, beat_n};
			fetch_left_reg <= 4'(cnt_after);
			instr_buf_reg <= instr_merge;
		end
	end

	// Next address and count: loaded from every fetched instruction, stepped per beat
	wire instr_complete = beat_done && fetching_reg && last_byte_beat;
	wire instr_is_move = instr_merge[31:30] == MOVE_OPCODE;
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			next_address_reg <= NEXT_ADDRESS_RST;
			byte_count_reg <= BYTE_COUNT_RST;
		end else begin
			if (instr_complete) begin
				next_address_reg <= instr_merge[63:32];
				byte_count_reg <= instr_merge[23:0];
			end else if (eng_move) begin
				if (!fixed_address_mode) begin
					next_address_reg <= next_address_reg + {29'h00000000, beat_n};
				end
				byte_count_reg <= cnt_after;
			end
			// Software access takes precedence over the engine step
			if (avs_wr_take && sel_addr) begin
				next_address_reg <= addr_wr;
			end
			if (avs_wr_take && sel_cnt) begin
				byte_count_reg <= cnt_wr[23:0];
			end
		end
	end

	// Move activity; a start strobe wins over completion in the same cycle
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			move_active_reg <= 1'b0;
			move_done_out <= 1'b0;
			instr_valid_out <= 1'b0;
			instr_word_out <= 64'h0000000000000000;
		end else begin
			move_done_out <= eng_move && last_byte_beat;
			instr_valid_out <= instr_complete;
			if (instr_complete) begin
				instr_word_out <= instr_merge;
			end
			if (sw_start || (instr_complete && instr_is_move && instr_merge[23:0] != 24'h000000)) begin
				move_active_reg <= 1'b1;
			end else if (eng_move && last_byte_beat) begin
				move_active_reg <= 1'b0;
			end
		end
	end

	// Memory bus cycle outputs, set up one cycle before each beat
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			mem_cycle_out <= 1'b0;
			mem_write_out <= 1'b0;
			mem_fetch_out <= 1'b0;
			mem_burst_last_out <= 1'b0;
			mem_addr_out <= 32'h00000000;
			mem_data_out <= 32'h00000000;
			mem_data_oe_out <= 1'b0;
			mem_parity_out <= 4'hF;
			byte_enable_n_out <= 4'hF;
			upper_byte_enable_n_out <= 1'b1;
			address_bit_zero_out <= 1'b0;
		end else if (state_reg == ST_SET) begin
			mem_cycle_out <= 1'b1;
			mem_write_out <= to_memory && !fetching_reg;
			mem_fetch_out <= fetching_reg;
			mem_burst_last_out <= last_byte_beat || (!fetching_reg && !burst_more);
			mem_addr_out <= bus_addr;
			mem_data_out <= wdata;
			mem_data_oe_out <= to_memory && !fetching_reg;
			mem_parity_out <= wpar;
			byte_enable_n_out <= be_n;
			upper_byte_enable_n_out <= legacy_word_mode ? bhe_n : 1'b1;
			address_bit_zero_out <= cur_addr[0];
		end else if (beat_done) begin
			mem_cycle_out <= 1'b0;
			mem_write_out <= 1'b0;
			mem_data_oe_out <= 1'b0;
			mem_burst_last_out <= 1'b0;
			byte_enable_n_out <= 4'hF;
			upper_byte_enable_n_out <= 1'b1;
		end
	end

	// Arbitration: wired-OR pulls low only while requesting; chain passes grant on
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			mem_req_out <= 1'b0;
			mem_req_oe_out <= 1'b0;
			grant_chain_out <= 1'b0;
		end else begin
			mem_req_out <= wired_or ? 1'b0 : want_bus;
			mem_req_oe_out <= wired_or ? want_bus : 1'b1;
			grant_chain_out <= !wired_or && mem_grant_in && !want_bus;
		end
	end

	// FIFO storage: up to four bytes enter per cycle
	always_ff @(posedge clk_sys_in) begin
		for (int j = 0; j < 4; j++) begin
			if (3'(j) < push_n) begin
				fifo_mem[wr_ptr_reg + AW'(j)] <= to_memory ? scsi_wr_byte_in : rx_byte[j];
			end
		end
	end

	// FIFO pointers and SCSI-side handshakes
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fifo_count_reg <= '0;
			scsi_wr_ready_out <= 1'b0;
			scsi_rd_valid_out <= 1'b0;
			scsi_rd_byte_out <= 8'h00;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push_n);
			rd_ptr_reg <= rd_ptr_next;
			fifo_count_reg <= fifo_count_next;
			scsi_wr_ready_out <= to_memory && (fifo_count_next < (AW+1)'(FIFO_DEPTH));
			// Only bytes already stored are offered, never one written this cycle
			scsi_rd_valid_out <= !to_memory && (count_after_pop != '0);
			scsi_rd_byte_out <= fifo_mem[rd_ptr_next];
		end
	end
endmodule : bus_master_lane_steering
`default_nettype wire

// file: verilog/lane_steering_pkg.sv
// Constants, field layout and state encoding for the bus-master lane steering block
`default_nettype none
package lane_steering_pkg;
	// Register byte offsets on the slave bus
	localparam logic [7:0] OFS_DMA_MODE = 8'h00;
	localparam logic [7:0] OFS_DMA_CONTROL = 8'h04;
	localparam logic [7:0] OFS_NEXT_ADDRESS = 8'h08;
	localparam logic [7:0] OFS_BYTE_COUNT = 8'h0C;
	localparam logic [7:0] OFS_SCSI_STATUS_ONE = 8'h10;
	localparam logic [7:0] OFS_SCSI_STATUS_TWO = 8'h14;
	localparam logic [7:0] OFS_DMA_FIFO = 8'h18;
	localparam logic [7:0] OFS_INSTR_LOW = 8'h1C;
	localparam logic [7:0] OFS_INSTR_HIGH = 8'h20;
	// Mode register fields
	localparam int MODE_FIXED_ADDR_BIT = 0;
	localparam int MODE_TO_MEMORY_BIT = 1;
	localparam int MODE_WIRED_OR_BIT = 2;
	localparam int MODE_LEGACY_BIT = 4;
	localparam int MODE_NARROW_BIT = 5;
	localparam int MODE_BURST_LSB = 6;
	// Control register fields
	localparam int CTRL_SCRIPT16_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	// Status register fields
	localparam int STAT1_OUT_LATCH_BIT = 5;
	localparam int STAT1_OUT_HOLD_BIT = 6;
	localparam int STAT1_IN_LATCH_BIT = 7;
	localparam int STAT2_COUNT_LSB = 4;
	localparam int FIFO_BUSY_BIT = 7;
	// Values after reset
	localparam logic [7:0] DMA_MODE_RST = 8'h00;
	localparam logic [7:0] DMA_CONTROL_RST = 8'h00;
	localparam logic [31:0] NEXT_ADDRESS_RST = 32'h00000000;
	localparam logic [23:0] BYTE_COUNT_RST = 24'h000000;
	// Instruction is two longwords; a move opcode starts a block move
	localparam logic [3:0] FETCH_BYTES = 4'h8;
	localparam logic [1:0] MOVE_OPCODE = 2'h0;
	localparam logic [1:0] BURST_MAX_CODE = 2'h3;
	localparam logic [3:0] BURST_MAX_WORDS = 4'h8;
	localparam logic [3:0] BURST_MIN_WORDS = 4'h2;
	// Engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARB = 2'b01,
		ST_SET = 2'b10,
		ST_BEAT = 2'b11
	} eng_state_t;
endpackage : lane_steering_pkg
`default_nettype wire

// file: dv/lane_steering_monitor.sv
// Port checker for the lane steering block
`timescale 1ns/10ps
`default_nettype none
module lane_steering_monitor (
	// Watched single-bit ports
	input wire logic clk_sys_in, rst_b_in, avs_read_in, avs_write_in, avs_waitrequest_out,
	input wire logic mem_grant_in, mem_ready_in, mem_cycle_out, mem_data_oe_out,
	input wire logic instr_valid_out, move_done_out,
	// Watched buses
	input wire logic [31:0] mem_addr_out, mem_data_out,
	input wire logic [3:0] mem_parity_out, byte_enable_n_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	// Register slave answers after exactly one wait cycle, for one cycle
	property p_wait_one; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
	a_wait_one: assert property (p_wait_one) else $error("slave answer late");
	property p_wait_pulse; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
	// Enables all off between beats
	property p_idle_be; !mem_cycle_out |-> byte_enable_n_out == 4'hF; endproperty
	a_idle_be: assert property (p_idle_be) else $error("enable outside beat");
	// A beat stands unchanged until the memory answers
	property p_hold; mem_cycle_out && !mem_ready_in |=> mem_cycle_out && $stable(mem_addr_out) && $stable(byte_enable_n_out); endproperty
	a_hold: assert property (p_hold) else $error("beat changed early");
	property p_gap; mem_cycle_out && mem_ready_in |=> !mem_cycle_out; endproperty
	a_gap: assert property (p_gap) else $error("no gap after beat");
	// Odd parity on every driven lane
	property p_parity; mem_data_oe_out |-> mem_parity_out == {~^mem_data_out[31:24], ~^mem_data_out[23:16], ~^mem_data_out[15:8], ~^mem_data_out[7:0]}; endproperty
	a_parity: assert property (p_parity) else $error("bad parity");
	property p_done; move_done_out |=> !move_done_out; endproperty
	a_done: assert property (p_done) else $error("done not a pulse");
	property p_instr; instr_valid_out |=> !instr_valid_out; endproperty
	a_instr: assert property (p_instr) else $error("fetch valid not a pulse");
	// First beat comes one set-up cycle after the grant edge
	property p_grant; $rose(mem_cycle_out) |-> $past(mem_grant_in, 2); endproperty
	a_grant: assert property (p_grant) else $error("beat without grant");
endmodule : lane_steering_monitor
bind bus_master_lane_steering lane_steering_monitor i_lane_steering_monitor (.*);
`default_nettype wire

// file: dv/mem_partner.sv
// Memory and arbiter model on the far side of the bus-master port
`timescale 1ns/10ps
`default_nettype none
module mem_partner (
	// Bench controls
	input wire logic clk_sys_in, wired_in, narrow_in, legacy_in,
	input wire logic [1:0] lat_in,
	// Bus from the block
	input wire logic mem_req_out, mem_req_oe_out, mem_cycle_out, mem_write_out,
	input wire logic upper_byte_enable_n_out, address_bit_zero_out,
	input wire logic [31:0] mem_addr_out, mem_data_out,
	input wire logic [3:0] byte_enable_n_out,
	// Answers
	output logic mem_grant_in = 1'b0,
	output logic mem_ready_in = 1'b0,
	output logic [31:0] mem_data_in = 32'h0
);
	logic [7:0] mem [256];
	logic [1:0] cnt = 2'h0;
	logic [7:0] b;
	logic e;
	int l;
	// Pattern is the inverted address
	initial for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
	// Grant, wait states and lane steering; idle lines toggle, never hold
	always @(posedge clk_sys_in) begin
		mem_ready_in <= 1'b0;
		mem_data_in <= ~mem_data_in;
		mem_grant_in <= mem_req_out | (wired_in & mem_req_oe_out);
		cnt <= (mem_cycle_out && !mem_ready_in) ? cnt + 2'h1 : 2'h0;
		if (mem_cycle_out && !mem_ready_in && cnt == lat_in) mem_ready_in <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			l = narrow_in || legacy_in ? k % 2 : k;
			e = legacy_in ? (k == 0 ? !address_bit_zero_out : k == 1 && !upper_byte_enable_n_out) : !byte_enable_n_out[k];
			b = (legacy_in ? {mem_addr_out[7:1], 1'b0} : {mem_addr_out[7:2], 2'b00}) + 8'(k);
			if (e && mem_ready_in && mem_cycle_out && mem_write_out) mem[b] <= mem_data_out[8*l +: 8];
			if (e && !mem_ready_in && mem_cycle_out && cnt == lat_in) mem_data_in[8*l +: 8] <= mem[b];
		end
	end
endmodule : mem_partner
`default_nettype wire

// file: dv/bus_master_lane_steering_tb.sv
// Self-checking bench for the lane steering block
`timescale 1ns/10ps
`default_nettype none
module bus_master_lane_steering_tb;
	import lane_steering_pkg::*;
	logic clk_sys_in = '0, rst_b_in = '0, avs_read_in = '0, avs_write_in = '0, fetch_req_in = '0;
	logic scsi_wr_valid_in = '0, scsi_rd_ready_in = '1, scsi_out_latch_full_in = '0;
	logic scsi_out_holding_full_in = '0, scsi_in_latch_full_in = '0, wired_in = '0, narrow_in = '0;
	logic legacy_in = '0, mem_grant_in, mem_ready_in, avs_waitrequest_out, mem_req_out;
	logic mem_req_oe_out, grant_chain_out, mem_cycle_out, mem_write_out, mem_fetch_out;
	logic mem_burst_last_out, mem_data_oe_out, upper_byte_enable_n_out, address_bit_zero_out;
	logic instr_valid_out, move_done_out, scsi_wr_ready_out, scsi_rd_valid_out;
	logic [1:0] lat_in = '0;
	logic [3:0] avs_byteenable_in = '1, scsi_fifo_count_in = '0, mem_parity_out, byte_enable_n_out;
	logic [7:0] avs_address_in = '0, scsi_wr_byte_in = '0, scsi_rd_byte_out;
	logic [31:0] avs_writedata_in = '0, fetch_addr_in = 32'h40, avs_readdata_out, mem_data_in;
	logic [31:0] mem_addr_out, mem_data_out, q;
	logic [63:0] instr_word_out;
	logic [13:0] bl [64];
	logic [7:0] rx [64];
	int n_errors = 0, comparisons = 0, nb = 0, nr = 0, ni = 0, nd = 0, n0, r0;
	bus_master_lane_steering i_bus_master_lane_steering (.*);
	mem_partner i_mem_partner (.*);
	always #20 clk_sys_in = ~clk_sys_in;
	// Logs of beats, streamed bytes and pulses
	always @(posedge clk_sys_in) begin
		if (mem_cycle_out && mem_ready_in) begin
			bl[nb] <= {upper_byte_enable_n_out, address_bit_zero_out, byte_enable_n_out, mem_addr_out[7:0]};
			nb <= nb + 1;
		end
		if (scsi_rd_valid_out && scsi_rd_ready_in) begin
			rx[nr] <= scsi_rd_byte_out;
			nr <= nr + 1;
		end
		ni <= ni + int'(instr_valid_out === 1'b1);
		nd <= nd + int'(move_done_out === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// One slave access; holds until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		@(posedge clk_sys_in);
		while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask : bus
	task automatic await(ref int n, input int t);
		while (n < t) @(posedge clk_sys_in);
	endtask : await
	task automatic push(input logic [7:0] v);
		scsi_wr_byte_in <= v;
		scsi_wr_valid_in <= 1'b1;
		@(posedge clk_sys_in);
		while (scsi_wr_ready_out !== 1'b1) @(posedge clk_sys_in);
	endtask : push
	task automatic t_regs;
		bus(1'b0, OFS_DMA_MODE, 32'h0);
		chk(q, 32'(DMA_MODE_RST));
		bus(1'b1, 8'h30, 32'hFFFFFFFF);
		bus(1'b0, 8'h30, 32'h0);
		chk(q, 32'h0);
	endtask : t_regs
	task automatic t_status(input logic ol, oh, il, input logic [3:0] c);
		scsi_out_latch_full_in <= ol;
		scsi_out_holding_full_in <= oh;
		scsi_in_latch_full_in <= il;
		scsi_fifo_count_in <= c;
		bus(1'b1, OFS_SCSI_STATUS_ONE, 32'h0);
		bus(1'b0, OFS_SCSI_STATUS_ONE, 32'h0);
		chk(q & 32'hE0, {24'h0, il, oh, ol, 5'h0});
		bus(1'b0, OFS_SCSI_STATUS_TWO, 32'h0);
		chk(q & 32'hF0, {24'h0, c, 4'h0});
	endtask : t_status
	task automatic t_fetch(input logic s16, input int n);
		// Partner must steer lanes by the fetch width, not the data width
		narrow_in <= s16;
		bus(1'b1, OFS_DMA_CONTROL, {31'h0, s16});
		n0 = nb;
		r0 = ni;
		fetch_req_in <= 1'b1;
		@(posedge clk_sys_in);
		fetch_req_in <= 1'b0;
		await(ni, r0 + 1);
		chk(nb - n0, n);
		chk(instr_word_out[31:0], 32'hBCBDBEBF);
		bus(1'b0, OFS_NEXT_ADDRESS, 32'h0);
		chk(q, 32'hB8B9BABB);
	endtask : t_fetch
	// Odd start, word, last byte in the legacy encoding, wired-OR request
	task automatic t_legacy;
		logic [13:0] e [3] = '{14'h1F81, 14'h0F82, 14'h2F84};
		wired_in <= 1'b1;
		legacy_in <= 1'b1;
		lat_in <= 2'h2;
		bus(1'b1, OFS_DMA_MODE, 32'h14);
		bus(1'b1, OFS_NEXT_ADDRESS, 32'h81);
		bus(1'b1, OFS_BYTE_COUNT, 32'h4);
		n0 = nb;
		r0 = nr;
		bus(1'b1, OFS_DMA_CONTROL, 32'h2);
		await(nr, r0 + 4);
		chk(nb - n0, 3);
		for (int k = 0; k < 3; k++) chk(bl[n0 + k], e[k]);
		for (int k = 0; k < 4; k++) chk(rx[r0 + k], 8'(~(8'h81 + 8'(k))));
		legacy_in <= 1'b0;
		wired_in <= 1'b0;
		lat_in <= 2'h0;
	endtask : t_legacy
	// Three bytes to offset one, written from the SCSI side
	task automatic t_write(input logic [7:0] m, input int n, input logic [13:0] e0, e1);
		narrow_in <= m[5];
		bus(1'b1, OFS_DMA_MODE, 32'(m));
		for (int k = 1; k < 4; k++) push(m + 8'(k));
		scsi_wr_valid_in <= 1'b0;
		bus(1'b1, OFS_NEXT_ADDRESS, 32'h41);
		bus(1'b1, OFS_BYTE_COUNT, 32'h3);
		n0 = nb;
		r0 = nd;
		bus(1'b1, OFS_DMA_CONTROL, 32'h2);
		await(nd, r0 + 1);
		chk(nb - n0, n);
		chk(bl[n0], e0);
		chk(bl[n0 + n - 1], e1);
		for (int k = 1; k < 4; k++) chk(i_mem_partner.mem[8'h40 + 8'(k)], m + 8'(k));
		bus(1'b0, OFS_NEXT_ADDRESS, 32'h0);
		chk(q, m[0] ? 32'h41 : 32'h44);
	endtask : t_write
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// Main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		@(posedge clk_sys_in);
		t_regs;
		t_status(1'b1, 1'b0, 1'b1, 4'hA);
		t_status(1'b0, 1'b1, 1'b0, 4'h5);
		t_fetch(1'b0, 2);
		t_fetch(1'b1, 4);
		t_legacy;
		t_write(8'h03, 1, 14'h3140, 14'h3140);
		t_write(8'h22, 2, 14'h3D40, 14'h2340);
		stop_test;
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_errors++;
		stop_test;
	end
endmodule : bus_master_lane_steering_tb
`default_nettype wire
